// file: rtl/sbc_ctrl.sv
// memory controller end: issues reads, writes, config loads, self refresh
// assumes the device end on the same clk_sys; read data returned as beats
`timescale 1ns/1ps
module sbc_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  sbc_if.ctl               link,
  input  wire logic        req_valid,
  input  wire logic [1:0]  req_op,
  input  wire logic [1:0]  req_bank,
  input  wire logic [8:0]  req_col,
  input  wire logic [15:0] wr_data,
  input  wire logic [2:0]  cfg_len,
  input  wire logic        cfg_order,
  input  wire logic [1:0]  cfg_latency,
  input  wire logic        cfg_single_write,
  input  wire logic [2:0]  cfg_coverage,
  input  wire logic [2:0]  cfg_drive,
  input  wire logic        sr_req,
  output logic             req_ready,
  output logic             wr_take,
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  typedef enum logic [2:0] {
    CS_IDLE  = 3'h0,
    CS_BUSY  = 3'h1,
    CS_MRD_B = 3'h2,
    CS_MRD_E = 3'h3,
    CS_SREF  = 3'h4
  } sbc_cstate_t;

  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_CFG   = 2'h2;
  localparam int NW = sbc_pkg::CNT_W;

  // smallest latency legal at this clock rate
  function automatic logic [1:0] min_latency(input int mhz);
    if (mhz <= sbc_pkg::CL1_MAX_MHZ)
      return 2'h1;
    else if (mhz <= sbc_pkg::CL2_MAX_MHZ)
      return 2'h2;
    return 2'h3;
  endfunction

  sbc_cstate_t  state;
  logic [NW-1:0] left;
  logic [2:0]    ctl_len;
  logic          ctl_wb;
  logic [1:0]    ctl_q;
  logic [1:0]    eff_q;
  logic [NW-1:0] nbeats;

  assign eff_q  = (cfg_latency < min_latency(sbc_pkg::CLK_MHZ) || cfg_latency == 2'h0)
                  ? min_latency(sbc_pkg::CLK_MHZ) : cfg_latency;
  assign nbeats = sbc_pkg::beat_count(ctl_len);

  // command sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state          <= CS_IDLE;
      left           <= '0;
      ctl_len        <= sbc_pkg::BASE_RESET[sbc_pkg::BL_LSB +: 3];
      ctl_wb         <= sbc_pkg::BASE_RESET[sbc_pkg::WB_BIT];
      ctl_q          <= sbc_pkg::BASE_RESET[sbc_pkg::CL_LSB +: 2];
      req_ready      <= 1'b1;
      wr_take        <= 1'b0;
      link.cmd       <= sbc_pkg::SBC_NOP;
      link.cke       <= 1'b1;
      link.bank      <= '0;
      link.addr      <= '0;
      link.ctl_dq    <= '0;
      link.ctl_dq_oe <= 1'b0;
    end
    else
    begin
      link.cmd <= sbc_pkg::SBC_NOP;
      case (state)
        CS_IDLE:
        begin
          link.ctl_dq_oe <= 1'b0;
          wr_take        <= 1'b0;
          if (sr_req)
          begin
            link.cmd  <= sbc_pkg::SBC_REFRESH;
            link.cke  <= 1'b0;
            req_ready <= 1'b0;
            state     <= CS_SREF;
          end
          else if (req_valid && req_op == OP_READ)
          begin
            link.cmd  <= sbc_pkg::SBC_READ;
            link.bank <= req_bank;
            link.addr <= {3'h0, req_col};
            left      <= nbeats + NW'(ctl_q); // bus stays the device's until done
            req_ready <= 1'b0;
            state     <= CS_BUSY;
          end
          else if (req_valid && req_op == OP_WRITE)
          begin
            link.cmd       <= sbc_pkg::SBC_WRITE;
            link.bank      <= req_bank;
            link.addr      <= {3'h0, req_col};
            link.ctl_dq    <= wr_data;
            link.ctl_dq_oe <= 1'b1;
            left           <= ctl_wb ? 10'h001 : nbeats;
            wr_take        <= !ctl_wb && nbeats > 10'h001;
            req_ready      <= 1'b0;
            state          <= CS_BUSY;
          end
          else if (req_valid && req_op == OP_CFG)
          begin
            // loads only from idle, operating mode forced normal
            link.cmd  <= sbc_pkg::SBC_LOAD;
            link.bank <= sbc_pkg::BANK_BASE;
            link.addr <= {2'h0, cfg_single_write, sbc_pkg::OPM_NORMAL,
                          1'b0, eff_q, cfg_order, cfg_len};
            ctl_len   <= cfg_len;
            ctl_wb    <= cfg_single_write;
            ctl_q     <= eff_q;
            left      <= NW'(sbc_pkg::MRD_CYC);
            req_ready <= 1'b0;
            state     <= CS_MRD_B;
          end
        end
        CS_BUSY:
        begin
          if (left <= 10'h001)
          begin
            link.ctl_dq_oe <= 1'b0;
            wr_take        <= 1'b0;
            req_ready      <= 1'b1;
            state          <= CS_IDLE;
          end
          else
          begin
            link.ctl_dq <= wr_data;
            wr_take     <= link.ctl_dq_oe && left > 10'h002;
            left        <= left - 10'h001;
          end
        end
        CS_MRD_B:
        begin
          if (left <= 10'h001)
          begin
            link.cmd  <= sbc_pkg::SBC_LOAD;
            link.bank <= sbc_pkg::BANK_EXT;
            link.addr <= {4'h0, cfg_drive, 2'h0, cfg_coverage};
            left      <= NW'(sbc_pkg::MRD_CYC);
            state     <= CS_MRD_E;
          end
          else
            left <= left - 10'h001;
        end
        CS_MRD_E:
        begin
          if (left <= 10'h001)
          begin
            req_ready <= 1'b1;
            state     <= CS_IDLE;
          end
          else
            left <= left - 10'h001;
        end
        CS_SREF:
        begin
          if (!sr_req)
          begin
            link.cke  <= 1'b1;
            req_ready <= 1'b1;
            state     <= CS_IDLE;
          end
        end
        default:
          state <= CS_IDLE;
      endcase
    end
  end

  // read beats captured on every edge the device drives valid data
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end
    else
    begin
      rd_valid <= link.dev_dq_oe;
      rd_data  <= link.dev_dq;
    end
  end
endmodule

// file: rtl/sbc_device.sv
// sdram device end: config words, burst column sequencing, read latency,
// self refresh pacing with partial coverage and drive level outputs
// assumes the controller drives the link from flops on the same clk_sys
//
// What this block does
// - length two: A1-A8 block, A0 start
// - length four: A2-A8 block, A0-A1 start
// - length eight: A3-A8 block, A0-A2 start
// - full page spans 512 columns, sequential only
// - burst wraps inside its own block
// - length one: exact column, order ignored
// - sequential adds index, interleaved xors index
// - controller loads operating mode zero only
// - data driven by r+q-1, valid r+q
// - read latency one, two or three
// - controller picks latency by clock frequency
// - option bit makes writes single location
// - bank bits 1,0 select extended word
// - extended word held until next load
// - controller zeroes extended bits 3,4,8-12
// - controller loads idle, then waits recovery
// - self refresh rate follows temperature
// - self refresh only covered array portion
// - coverage codes all, half, quarter, eighth, sixteenth
// - drive codes full, half, quarter, eighth, three quarters
// - base bits 2-0 set burst length
// - base bit 3 selects burst order
// - bits 6-4 latency, 8-7 operating mode
`timescale 1ns/1ps
module sbc_device (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  sbc_if.dev               link,
  input  wire logic        temp_hot,
  input  wire logic        temp_cold,
  output logic [2:0]       drive_level,
  output logic [2:0]       partial_refresh_coverage,
  output logic             sr_active,
  output logic             refresh_pulse,
  output logic [3:0]       refresh_bank_mask,
  output logic [1:0]       refresh_row_span
);
  localparam int CW = sbc_pkg::COL_W;
  localparam int NW = sbc_pkg::CNT_W;

  logic [sbc_pkg::BASE_W-1:0] base_word;
  logic [sbc_pkg::EXT_W-1:0]  extended_config_word;
  logic [sbc_pkg::DQ_W-1:0]   mem [0:sbc_pkg::PAGE_COLS-1];
  logic                       brst_act;
  logic                       brst_wr;
  logic                       brst_il;
  logic [CW-1:0]              brst_start;
  logic [NW-1:0]              brst_idx;
  logic [NW-1:0]              brst_len;
  logic [1:0]                 pipe_v;
  logic [CW-1:0]              pipe_col [0:1];
  logic [1:0]                 hot_sync;
  logic [1:0]                 cold_sync;
  logic [NW-1:0]              sr_count;

  // column of beat idx: block bits kept, offset wraps or xors inside
  function automatic logic [CW-1:0] col_of(input logic [CW-1:0] start,
                                           input logic [NW-1:0] idx,
                                           input logic [NW-1:0] len,
                                           input logic          il);
    logic [CW-1:0] mask;
    logic [CW-1:0] off;
    mask = CW'(len - 10'h001);
    if (il)
      off = start ^ CW'(idx);
    else
      off = CW'(start + CW'(idx));
    return (start & ~mask) | (off & mask);
  endfunction

  // current beat, either opened by this command or carried by the engine
  logic          new_rd;
  logic          new_wr;
  logic          cur_valid;
  logic          cur_wr;
  logic          cur_il;
  logic [CW-1:0] cur_start;
  logic [NW-1:0] cur_idx;
  logic [NW-1:0] cur_len;
  logic [CW-1:0] cur_col;
  logic [2:0]    len_code;

  assign new_rd   = (link.cmd == sbc_pkg::SBC_READ);
  assign new_wr   = (link.cmd == sbc_pkg::SBC_WRITE);
  assign len_code = base_word[sbc_pkg::BL_LSB +: 3];

  always_comb
  begin
    if (new_rd || new_wr)
    begin
      cur_valid = 1'b1;
      cur_wr    = new_wr;
      cur_start = link.addr[CW-1:0];
      cur_idx   = '0;
      if (new_wr && base_word[sbc_pkg::WB_BIT])
        cur_len = 10'h001;
      else
        cur_len = sbc_pkg::beat_count(len_code);
      // full page has no interleaved form
      cur_il = base_word[sbc_pkg::BT_BIT] && (len_code != sbc_pkg::BL_FULL);
    end
    else
    begin
      cur_valid = brst_act;
      cur_wr    = brst_wr;
      cur_start = brst_start;
      cur_idx   = brst_idx;
      cur_len   = brst_len;
      cur_il    = brst_il;
    end
    cur_col = col_of(cur_start, cur_idx, cur_len, cur_il);
  end

  // config word loads, selected by bank bits
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_word            <= sbc_pkg::BASE_RESET;
      extended_config_word <= sbc_pkg::EXT_RESET;
    end
    else if (link.cmd == sbc_pkg::SBC_LOAD)
    begin
      if (link.bank == sbc_pkg::BANK_EXT)
        extended_config_word <= {link.bank, link.addr};
      else if (link.bank == sbc_pkg::BANK_BASE)
        base_word <= link.addr[sbc_pkg::BASE_W-1:0];
    end
  end

  // burst engine; stop or a new read or write truncates the running burst
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brst_act   <= 1'b0;
      brst_wr    <= 1'b0;
      brst_il    <= 1'b0;
      brst_start <= '0;
      brst_idx   <= '0;
      brst_len   <= 10'h001;
    end
    else if (link.cmd == sbc_pkg::SBC_STOP)
      brst_act <= 1'b0;
    else
    begin
      brst_act   <= cur_valid && (cur_idx + 10'h001 < cur_len);
      brst_wr    <= cur_wr;
      brst_il    <= cur_il;
      brst_start <= cur_start;
      brst_idx   <= cur_idx + 10'h001;
      brst_len   <= cur_len;
    end
  end

  // write beats take the data coincident with each beat
  always_ff @(posedge clk_sys)
  begin
    if (cur_valid && cur_wr && link.cmd != sbc_pkg::SBC_STOP)
      mem[cur_col] <= link.ctl_dq;
  end

  // read beat delay line for latency two and three
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pipe_v      <= '0;
      pipe_col[0] <= '0;
      pipe_col[1] <= '0;
    end
    else
    begin
      pipe_v[0]   <= cur_valid && !cur_wr && link.cmd != sbc_pkg::SBC_STOP;
      pipe_v[1]   <= pipe_v[0];
      pipe_col[0] <= cur_col;
      pipe_col[1] <= pipe_col[0];
    end
  end

  // output stage updates at edge r+q-1 so data is valid at r+q
  logic          sel_v;
  logic [CW-1:0] sel_col;

  always_comb
  begin
    case (base_word[sbc_pkg::CL_LSB +: 3])
      3'h1:
      begin
        sel_v   = cur_valid && !cur_wr && link.cmd != sbc_pkg::SBC_STOP;
        sel_col = cur_col;
      end
      3'h2:
      begin
        sel_v   = pipe_v[0];
        sel_col = pipe_col[0];
      end
      default:
      begin
        sel_v   = pipe_v[1];
        sel_col = pipe_col[1];
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.dev_dq    <= '0;
      link.dev_dq_oe <= 1'b0;
    end
    else
    begin
      link.dev_dq    <= mem[sel_col];
      link.dev_dq_oe <= sel_v;
    end
  end

  // temperature sensor levels cross in through two flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hot_sync  <= '0;
      cold_sync <= '0;
    end
    else
    begin
      hot_sync  <= {hot_sync[0], temp_hot};
      cold_sync <= {cold_sync[0], temp_cold};
    end
  end

  // self refresh entry on refresh with cke low, exit on cke high
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sr_active <= 1'b0;
    else if (link.cke)
      sr_active <= 1'b0;
    else if (link.cmd == sbc_pkg::SBC_REFRESH)
      sr_active <= 1'b1;
  end

  // interval shortens when hot, lengthens when cold
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr_count      <= '0;
      refresh_pulse <= 1'b0;
    end
    else if (!sr_active)
    begin
      sr_count      <= '0;
      refresh_pulse <= 1'b0;
    end
    else if (sr_count == '0)
    begin
      refresh_pulse <= 1'b1;
      if (hot_sync[1])
        sr_count <= NW'(sbc_pkg::REFRESH_CYC / 2 - 1);
      else if (cold_sync[1])
        sr_count <= NW'(sbc_pkg::REFRESH_CYC * 2 - 1);
      else
        sr_count <= NW'(sbc_pkg::REFRESH_CYC - 1);
    end
    else
    begin
      refresh_pulse <= 1'b0;
      sr_count      <= sr_count - 10'h001;
    end
  end

  // coverage decode; reserved codes keep the whole array
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refresh_bank_mask <= 4'hF;
      refresh_row_span  <= 2'h0;
    end
    else
    begin
      case (extended_config_word[sbc_pkg::COV_LSB +: 3])
        3'h1:
        begin
          refresh_bank_mask <= 4'h3;
          refresh_row_span  <= 2'h0;
        end
        3'h2:
        begin
          refresh_bank_mask <= 4'h1;
          refresh_row_span  <= 2'h0;
        end
        3'h5:
        begin
          refresh_bank_mask <= 4'h1;
          refresh_row_span  <= 2'h1;
        end
        3'h6:
        begin
          refresh_bank_mask <= 4'h1;
          refresh_row_span  <= 2'h2;
        end
        default:
        begin
          refresh_bank_mask <= 4'hF;
          refresh_row_span  <= 2'h0;
        end
      endcase
    end
  end

  assign drive_level              = extended_config_word[sbc_pkg::DRV_LSB +: 3];
  assign partial_refresh_coverage = extended_config_word[sbc_pkg::COV_LSB +: 3];
endmodule

// file: rtl/sbc_if.sv
// command and data link between memory controller and sdram device
// assumes both ends clocked by the same clk_sys; ctl_dq and dev_dq are separate one-way lines
`timescale 1ns/1ps
interface sbc_if;
  sbc_pkg::sbc_cmd_t            cmd;
  logic                         cke;
  logic [1:0]                   bank;
  logic [sbc_pkg::ADDR_W-1:0]   addr;
  logic [sbc_pkg::DQ_W-1:0]     ctl_dq;
  logic                         ctl_dq_oe;
  logic [sbc_pkg::DQ_W-1:0]     dev_dq;
  logic                         dev_dq_oe;

  modport dev (
    input  cmd, cke, bank, addr, ctl_dq, ctl_dq_oe,
    output dev_dq, dev_dq_oe
  );
  modport ctl (
    output cmd, cke, bank, addr, ctl_dq, ctl_dq_oe,
    input  dev_dq, dev_dq_oe
  );
endinterface

// file: rtl/sbc_pkg.sv
// constants and types shared by both ends of the sdram burst/config link
// assumes one 10 MHz system clock common to controller and device
package sbc_pkg;
  localparam int COL_W   = 9;
  localparam int ADDR_W  = 12;
  localparam int DQ_W    = 16;
  localparam int CNT_W   = 10;
  localparam int CLK_NS  = 100;
  localparam int CLK_MHZ = 1000 / CLK_NS;
  // base word field positions
  localparam int BL_LSB  = 0;
  localparam int BT_BIT  = 3;
  localparam int CL_LSB  = 4;
  localparam int OPM_LSB = 7;
  localparam int WB_BIT  = 9;
  localparam int BASE_W  = 10;
  // extended word field positions
  localparam int COV_LSB = 0;
  localparam int DRV_LSB = 5;
  localparam int EXT_W   = 14;
  localparam logic [BASE_W-1:0] BASE_RESET = 10'h020;
  localparam logic [EXT_W-1:0]  EXT_RESET  = 14'h2000;
  localparam logic [1:0] BANK_BASE = 2'h0;
  localparam logic [1:0] BANK_EXT  = 2'h2;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  // burst length codes
  localparam logic [2:0] BL_1    = 3'h0;
  localparam logic [2:0] BL_2    = 3'h1;
  localparam logic [2:0] BL_4    = 3'h2;
  localparam logic [2:0] BL_8    = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [CNT_W-1:0] PAGE_COLS = 10'h200;
  // latency limits in MHz
  localparam int CL1_MAX_MHZ = 50;
  localparam int CL2_MAX_MHZ = 83;
  // mode load recovery and self refresh interval
  localparam int MRD_NS      = 200;
  localparam int MRD_CYC     = (MRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REFRESH_NS  = 15600;
  localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;

  typedef enum logic [2:0] {
    SBC_NOP     = 3'h0,
    SBC_READ    = 3'h1,
    SBC_WRITE   = 3'h2,
    SBC_LOAD    = 3'h3,
    SBC_STOP    = 3'h4,
    SBC_REFRESH = 3'h5
  } sbc_cmd_t;

  // beats in a burst for a length code; reserved codes act as one beat
  function automatic logic [CNT_W-1:0] beat_count(input logic [2:0] code);
    logic [CNT_W-1:0] n;
    n = 10'h001;
    case (code)
      BL_2:    n = 10'h002;
      BL_4:    n = 10'h004;
      BL_8:    n = 10'h008;
      BL_FULL: n = PAGE_COLS;
      default: n = 10'h001;
    endcase
    return n;
  endfunction
endpackage

// file: verif/sbc_link_chk.sv
// link checker: config loads, read latency, burst lengths, write option
// assumes one clk_sys domain; instantiated beside the link interface
`timescale 1ns/1ps
module sbc_link_chk (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input sbc_pkg::sbc_cmd_t               cmd,
  input wire logic [1:0]                 bank,
  input wire logic [sbc_pkg::ADDR_W-1:0] addr,
  input wire logic                       ctl_dq_oe,
  input wire logic                       dev_dq_oe
);
  logic [2:0] lat;
  logic [2:0] len;
  logic       wb;
  logic [3:0] rd_hist;
  logic       ld;
  assign ld = (cmd == sbc_pkg::SBC_LOAD);

  // base word as last loaded over the link
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      lat <= 3'h2;
      len <= 3'h0;
      wb  <= 1'b0;
    end
    else if (ld && bank == sbc_pkg::BANK_BASE)
    begin
      lat <= addr[6:4];
      len <= addr[2:0];
      wb  <= addr[9];
    end

  // history of read commands, one bit per edge
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      rd_hist <= 4'h0;
    else
      rd_hist <= {rd_hist[2:0], cmd == sbc_pkg::SBC_READ};

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_mode_normal: assert property (
    ld && bank == sbc_pkg::BANK_BASE |-> addr[8:7] == sbc_pkg::OPM_NORMAL)
    else $error("operating mode not normal");
  // bit 7 is the top of the drive field (code 100 is three quarters drive)
  a_ext_zero_bits: assert property (
    ld && bank == sbc_pkg::BANK_EXT |-> addr[11:8] == 4'h0 && addr[4:3] == 2'h0
      && addr[7:5] <= 3'h4)
    else $error("extended word reserved bits set");
  a_load_bank_sel: assert property (
    ld |-> bank == sbc_pkg::BANK_BASE || bank == sbc_pkg::BANK_EXT)
    else $error("load to unknown word");
  a_lat_legal: assert property (
    ld && bank == sbc_pkg::BANK_BASE |-> addr[6:4] inside {3'h1, 3'h2, 3'h3})
    else $error("illegal latency code");
  a_load_idle: assert property (
    ld |-> !dev_dq_oe && !ctl_dq_oe ##1 cmd == sbc_pkg::SBC_NOP)
    else $error("load while busy or no recovery");
  a_read_latency: assert property (
    lat inside {3'h1, 3'h2, 3'h3} && rd_hist[lat - 3'h1] |-> dev_dq_oe)
    else $error("read data late");
  a_read_eight: assert property (
    $rose(dev_dq_oe) && len == sbc_pkg::BL_8 |-> dev_dq_oe [*8] ##1 !dev_dq_oe)
    else $error("read burst not eight beats");
  a_write_four: assert property (
    cmd == sbc_pkg::SBC_WRITE && !wb && len == sbc_pkg::BL_4 |-> ctl_dq_oe [*4] ##1 !ctl_dq_oe)
    else $error("write burst not four beats");
  a_single_write: assert property (
    cmd == sbc_pkg::SBC_WRITE && wb |-> ctl_dq_oe ##1 !ctl_dq_oe)
    else $error("single write drove more beats");

  c_read_lat3: cover property (cmd == sbc_pkg::SBC_READ && lat == 3'h3);
  c_ext_load: cover property (ld && bank == sbc_pkg::BANK_EXT);
  c_single_wr: cover property (cmd == sbc_pkg::SBC_WRITE && wb);
endmodule

// file: verif/sdram_burst_and_mode_config_tb.sv
// testbench: controller and device joined by the link, memory model in bench
// assumes 10 MHz clk_sys; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module sdram_burst_and_mode_config_tb;
  logic        clk_sys, rst_n, req_valid, cfg_order, cfg_single_write;
  logic        sr_req, temp_hot, temp_cold, req_ready, wr_take, rd_valid;
  logic        sr_active, refresh_pulse, cur_il, cur_sw;
  logic [1:0]  req_op, req_bank, cfg_latency, refresh_row_span;
  logic [8:0]  req_col;
  logic [15:0] wr_data, rd_data;
  logic [15:0] mem[512];
  logic [2:0]  cfg_len, cfg_coverage, cfg_drive, drive_level, partial_refresh_coverage;
  logic [3:0]  refresh_bank_mask;
  int          fail_count, tests_run, seed, cur_n, cur_q;
  int          cvs[5] = '{0, 1, 2, 5, 6};
  int          msks[5] = '{15, 3, 1, 1, 1};
  int          spans[5] = '{0, 0, 0, 1, 2};

  sbc_if link_if ();
  sbc_ctrl sbc_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if), .req_valid(req_valid),
    .req_op(req_op), .req_bank(req_bank), .req_col(req_col), .wr_data(wr_data),
    .cfg_len(cfg_len), .cfg_order(cfg_order), .cfg_latency(cfg_latency),
    .cfg_single_write(cfg_single_write), .cfg_coverage(cfg_coverage), .cfg_drive(cfg_drive),
    .sr_req(sr_req), .req_ready(req_ready), .wr_take(wr_take), .rd_valid(rd_valid),
    .rd_data(rd_data));
  sbc_device sbc_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if),
    .temp_hot(temp_hot), .temp_cold(temp_cold), .drive_level(drive_level),
    .partial_refresh_coverage(partial_refresh_coverage), .sr_active(sr_active),
    .refresh_pulse(refresh_pulse), .refresh_bank_mask(refresh_bank_mask),
    .refresh_row_span(refresh_row_span));
  sbc_link_chk sbc_link_chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cmd(link_if.cmd),
    .bank(link_if.bank), .addr(link_if.addr), .ctl_dq_oe(link_if.ctl_dq_oe),
    .dev_dq_oe(link_if.dev_dq_oe));

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_idle();
    for (int t = 0; t < 1000 && req_ready !== 1'b1; t++)
      tick();
    check("req_ready", 16'h0001, 16'(req_ready));
  endtask

  // column of access i for a start column, burst length and order
  function automatic int col_at(int s, int n, logic il, int i);
    if (n == 512)
      return (s + i) % 512;
    return (s / n) * n + (il ? ((s % n) ^ i) : ((s + i) % n));
  endfunction

  // one user request, held until the accepting edge
  task automatic issue(logic [1:0] op, int col);
    wait_idle();
    req_valid = 1'b1;
    req_op = op;
    req_col = col[8:0];
    req_bank = 2'($random(seed));
    tick();
    req_valid = 1'b0;
  endtask

  task automatic load_config(int ln, logic od, int lt, logic sw, int cv, int dv);
    cfg_len = 3'(ln);
    cfg_order = od;
    cfg_latency = 2'(lt);
    cfg_single_write = sw;
    cfg_coverage = 3'(cv);
    cfg_drive = 3'(dv);
    cur_n = (ln == 7) ? 512 : (1 << ln);
    cur_il = od;
    cur_sw = sw;
    cur_q = lt;
    issue(2'h2, 0);
    wait_idle();
    check("drive_level", 16'(dv), 16'(drive_level));
    check("coverage", 16'(cv), 16'(partial_refresh_coverage));
  endtask

  // write beats with random data, model memory follows the column order
  task automatic write_burst(int col);
    int n;
    n = cur_sw ? 1 : cur_n;
    wr_data = 16'($random(seed));
    mem[col_at(col, n, cur_il, 0)] = wr_data;
    issue(2'h1, col);
    for (int k = 1; k < n; k++)
    begin
      check("wr_take", 16'h0001, 16'(wr_take));
      wr_data = 16'($random(seed));
      mem[col_at(col, n, cur_il, k)] = wr_data;
      tick();
    end
    check("wr_take_end", 16'h0000, 16'(wr_take));
    wait_idle();
  endtask

  task automatic read_burst(int col);
    int i;
    int first;
    i = 0;
    first = -1;
    issue(2'h0, col);
    for (int t = 0; t < cur_n + 8; t++)
    begin
      if (rd_valid === 1'b1)
      begin
        if (first < 0)
          first = t;
        check("rd_data", mem[col_at(col, cur_n, cur_il, i)], rd_data);
        i++;
      end
      tick();
    end
    check("beats", 16'(cur_n), 16'(i));
    // valid at edge r+q, registered by the controller one edge later
    check("first_beat", 16'(cur_q + 1), 16'(first));
  endtask

  // self refresh: interval by temperature, coverage as bank mask and row span
  task automatic self_refresh(int m);
    int t;
    int per;
    per = (m % 3 == 0) ? sbc_pkg::REFRESH_CYC :
          (m % 3 == 1) ? sbc_pkg::REFRESH_CYC / 2 : sbc_pkg::REFRESH_CYC * 2;
    sr_req = 1'b1;
    for (t = 0; t < 800 && refresh_pulse !== 1'b1; t++)
      tick();
    tick();
    for (t = 1; t < 800 && refresh_pulse !== 1'b1; t++)
      tick();
    check("interval", 16'(per), 16'(t));
    check("sr_active", 16'h0001, 16'(sr_active));
    check("bank_mask", 16'(msks[m]), 16'(refresh_bank_mask));
    check("row_span", 16'(spans[m]), 16'(refresh_row_span));
    sr_req = 1'b0;
    wait_idle();
  endtask

  // main sequence
  initial
  begin
    seed = 32'hB05A213B;
    {rst_n, req_valid, cfg_order, cfg_single_write, sr_req, temp_hot, temp_cold} = '0;
    {req_op, req_bank, req_col, wr_data, cfg_len, cfg_latency, cfg_coverage, cfg_drive} = '0;
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    load_config(7, 1'b0, 2, 1'b0, 0, 0);
    write_burst(0);
    read_burst($random(seed) & 511);
    for (int c = 0; c < 8; c++)
    begin
      load_config(c % 4, 1'(c / 4), c % 3 + 1, 1'b0, cvs[c % 5], c % 5);
      read_burst($random(seed) & 511);
      write_burst($random(seed) & 511);
      read_burst($random(seed) & 511);
      check("drive_hold", 16'(c % 5), 16'(drive_level));
    end
    load_config(3, 1'b1, 3, 1'b1, 0, 4);
    write_burst(13);
    read_burst(10);
    for (int m = 0; m < 5; m++)
    begin
      temp_hot = (m % 3 == 1);
      temp_cold = (m % 3 == 2);
      load_config(0, 1'b0, 1, 1'b0, cvs[m], m);
      self_refresh(m);
    end
    print_verdict();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #(100 * 40000);
    fail_count++;
    print_verdict();
  end
endmodule
